// [lcp_map.vh]
// Contract
// - write-only line count register, resets to 240
// - display start address readable, writable, resets zero
// - start address: eight low bits, six high
// - period zero toggles alternation once per frame
// - period N toggles alternation every N lines
// - data port moves one byte at index
// - index increments after each data port access
// - data port content undefined after reset
// - index read/write, two registers, resets to zero
// - data port and index for reduced-pin use
// - register access while select and strobe low
// - vram access during select and strobe overlap
// - cycle steal access takes one to three clocks
// - latency counted in divided internal clocks
// - read data valid before wait is released
// - lcd outputs synchronous to internal clock
// - three-bit divider selects none to sixteen
`ifndef LCP_MAP_VH
`define LCP_MAP_VH
`define LCP_OFS_VLINES 5'h08
`define LCP_OFS_START_LOW 5'h0a
`define LCP_OFS_START_HIGH 5'h0c
`define LCP_OFS_ALT_PERIOD 5'h0e
`define LCP_OFS_DATA_PORT 5'h10
`define LCP_OFS_INDEX_LOW 5'h12
`define LCP_OFS_INDEX_HIGH 5'h14
`define LCP_RST_VLINES 8'hf0
`define LCP_RST_START 14'h0000
`define LCP_RST_ALT_PERIOD 8'h00
`define LCP_RST_INDEX 14'h0000
`define LCP_VRAM_LAST 14'h257f
`define LCP_VRAM_BYTES 9600
`define LCP_HIGH_LSB 8
`define LCP_HIGH_WIDTH 6
`define LCP_DIV_NONE 3'h0
`define LCP_DIV_2 3'h1
`define LCP_DIV_4 3'h2
`define LCP_DIV_8 3'h3
`define LCP_DIV_16 3'h4
`define LCP_STEAL_LAST_PHASE 2'h2
`define LCP_LINE_TICKS 16'h0028
`endif

// [lcp_regs.v]
`include "lcp_map.vh"

module lcp_regs #(
	parameter [15:0] LINE_TICKS = `LCP_LINE_TICKS
) (
	input wire clk,
	input wire rst,
	input wire [13:0] addr,
	input wire [7:0] data_in,
	output reg [7:0] data_out,
	output wire data_oe,
	input wire register_select_n,
	input wire vram_select_n,
	input wire low_byte_write_n,
	input wire high_byte_write_n,
	input wire read_n,
	output reg wait_n,
	input wire steal_mode,
	input wire [2:0] osc_div_sel,
	output reg line_pulse,
	output reg frame_mark,
	output reg lcd_alternation,
	output reg [13:0] display_start
);

	localparam ST_IDLE = 2'h0;
	localparam ST_STEAL = 2'h1;
	localparam ST_HOLD = 2'h2;
	localparam ST_REL = 2'h3;

	// pin inputs: two flops before any logic
	reg [20:0] pin_meta;
	reg [20:0] pin_sync;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_meta <= 21'h1fffff;
			pin_sync <= 21'h1fffff;
		end else begin
			pin_meta <= {register_select_n, vram_select_n, low_byte_write_n,
				high_byte_write_n, read_n, data_in, 8'hff};
			pin_sync <= pin_meta;
		end
	end
	reg [13:0] addr_meta;
	reg [13:0] addr_s;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			addr_meta <= 14'h0000;
			addr_s <= 14'h0000;
		end else begin
			addr_meta <= addr;
			addr_s <= addr_meta;
		end
	end
	wire rsel_n = pin_sync[20];
	wire msel_n = pin_sync[19];
	wire lwr_n = pin_sync[18];
	wire hwr_n = pin_sync[17];
	wire rd_n = pin_sync[16];
	wire [7:0] din = pin_sync[15:8];

	// overlap of select with a strobe
	wire reg_act = ~rsel_n & (~lwr_n | ~rd_n);
	wire mem_act = ~msel_n & (~lwr_n | ~hwr_n | ~rd_n);
	reg reg_act_q;
	reg mem_act_q;
	reg reg_wr_q;
	reg [7:0] din_q;
	// offset held from the overlap: the address may move as strobes rise
	reg [4:0] ofs_q;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_act_q <= 1'b0;
			mem_act_q <= 1'b0;
			reg_wr_q <= 1'b0;
			din_q <= 8'h00;
			ofs_q <= 5'h00;
		end else begin
			reg_act_q <= reg_act;
			mem_act_q <= mem_act;
			if (reg_act | mem_act) begin
				reg_wr_q <= ~lwr_n | ~hwr_n;
				din_q <= din;
				ofs_q <= addr_s[4:0];
			end
		end
	end
	wire reg_start = reg_act & ~reg_act_q;
	wire reg_end = ~reg_act & reg_act_q;
	wire mem_start = mem_act & ~mem_act_q;

	// internal clock tick from the divider field
	reg [3:0] div_cnt;
	reg [3:0] div_mask;
	always @* begin
		case (osc_div_sel)
		`LCP_DIV_NONE: div_mask = 4'h0;
		`LCP_DIV_2: div_mask = 4'h1;
		`LCP_DIV_4: div_mask = 4'h3;
		`LCP_DIV_8: div_mask = 4'h7;
		`LCP_DIV_16: div_mask = 4'hf;
		default: div_mask = 4'h0;
		endcase
	end
	wire tick = ((div_cnt & div_mask) == div_mask);
	always @(posedge clk or posedge rst) begin
		if (rst)
			div_cnt <= 4'h0;
		else
			div_cnt <= div_cnt + 4'h1;
	end

	// registers
	reg [7:0] vertical_lines;
	reg [7:0] alternation_period;
	reg [13:0] vram_index;
	reg [7:0] vram [0:`LCP_VRAM_BYTES-1];

	function in_range;
		input [13:0] a;
		begin
			in_range = (a <= `LCP_VRAM_LAST);
		end
	endfunction

	function [13:0] next_index_of;
		input [13:0] a;
		begin
			if (a >= `LCP_VRAM_LAST)
				next_index_of = `LCP_RST_INDEX;
			else
				next_index_of = a + 14'h0001;
		end
	endfunction

	wire [4:0] ofs = addr_s[4:0];
	wire port_sel = (ofs_q == `LCP_OFS_DATA_PORT);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			vertical_lines <= `LCP_RST_VLINES;
			display_start <= `LCP_RST_START;
			alternation_period <= `LCP_RST_ALT_PERIOD;
			vram_index <= `LCP_RST_INDEX;
		end else if (reg_end) begin
			if (reg_wr_q) begin
				case (ofs_q)
				`LCP_OFS_VLINES: vertical_lines <= din_q;
				`LCP_OFS_START_LOW: display_start[7:0] <= din_q;
				`LCP_OFS_START_HIGH: display_start[13:8] <=
					din_q[`LCP_HIGH_WIDTH-1:0];
				`LCP_OFS_ALT_PERIOD: alternation_period <= din_q;
				`LCP_OFS_INDEX_LOW: vram_index[7:0] <= din_q;
				`LCP_OFS_INDEX_HIGH: vram_index[13:8] <=
					din_q[`LCP_HIGH_WIDTH-1:0];
				default: ;
				endcase
			end
			if (port_sel)
				vram_index <= next_index_of(vram_index);
		end
	end

	// vram access control, cycle steal wait
	reg [1:0] state;
	reg [1:0] steal_phase;
	reg [13:0] mem_addr;
	reg mem_wr;
	always @(posedge clk or posedge rst) begin
		if (rst)
			steal_phase <= 2'h0;
		else if (tick)
			steal_phase <= (steal_phase == `LCP_STEAL_LAST_PHASE) ?
				2'h0 : steal_phase + 2'h1;
	end

	wire port_wr = reg_end & reg_wr_q & port_sel;
	wire steal_done = tick & (steal_phase == `LCP_STEAL_LAST_PHASE);
	wire direct_wr = mem_act & ~mem_act_q & ~steal_mode &
		(~lwr_n | ~hwr_n);
	wire steal_wr = (state == ST_STEAL) & steal_done & mem_wr;

	always @(posedge clk) begin
		if (port_wr & in_range(vram_index))
			vram[vram_index] <= din_q;
		else if (direct_wr & in_range(addr_s))
			vram[addr_s] <= din;
		else if (steal_wr & in_range(mem_addr))
			vram[mem_addr] <= din_q;
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			wait_n <= 1'b1;
			mem_addr <= 14'h0000;
			mem_wr <= 1'b0;
		end else begin
			case (state)
			ST_IDLE: begin
				if (mem_start & steal_mode) begin
					state <= ST_STEAL;
					wait_n <= 1'b0;
					mem_addr <= addr_s;
					mem_wr <= ~lwr_n | ~hwr_n;
				end
			end
			ST_STEAL: begin
				// phase counter gives one to three ticks
				if (steal_done)
					state <= ST_REL;
			end
			ST_REL: begin
				// read data already loaded one edge earlier
				wait_n <= 1'b1;
				state <= ST_HOLD;
			end
			ST_HOLD: begin
				// new wait only after the strobes go high
				if (~mem_act)
					state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// read data: flop ahead of the output, set before wait rises
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			data_out <= 8'h00;
		end else if (reg_start & ~rd_n) begin
			case (ofs)
			`LCP_OFS_START_LOW: data_out <= display_start[7:0];
			`LCP_OFS_START_HIGH: data_out <= {2'h0, display_start[13:8]};
			`LCP_OFS_INDEX_LOW: data_out <= vram_index[7:0];
			`LCP_OFS_INDEX_HIGH: data_out <= {2'h0, vram_index[13:8]};
			`LCP_OFS_DATA_PORT: data_out <= in_range(vram_index) ?
				vram[vram_index] : 8'h00;
			default: data_out <= 8'h00;
			endcase
		end else if (mem_start & ~rd_n & ~steal_mode) begin
			data_out <= in_range(addr_s) ? vram[addr_s] : 8'h00;
		end else if ((state == ST_STEAL) & steal_done & ~mem_wr) begin
			data_out <= in_range(mem_addr) ?
				vram[mem_addr] : 8'h00;
		end
	end
	assign data_oe = ~rd_n & ((reg_act & reg_act_q) |
		(mem_act & mem_act_q & (state != ST_STEAL)));

	// lcd timing, advanced only on internal ticks
	reg [15:0] tick_cnt;
	reg [7:0] line_cnt;
	reg [7:0] alt_cnt;
	wire line_end = tick & (tick_cnt == LINE_TICKS - 16'h0001);
	wire frame_end = line_end & (line_cnt >= vertical_lines - 8'h01);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt <= 16'h0000;
			line_cnt <= 8'h00;
			alt_cnt <= 8'h00;
			line_pulse <= 1'b0;
			frame_mark <= 1'b0;
			lcd_alternation <= 1'b0;
		end else begin
			if (tick)
				tick_cnt <= line_end ? 16'h0000 : tick_cnt + 16'h0001;
			line_pulse <= line_end;
			frame_mark <= frame_end;
			if (line_end)
				line_cnt <= frame_end ? 8'h00 : line_cnt + 8'h01;
			if (alternation_period == 8'h00) begin
				alt_cnt <= 8'h00;
				if (frame_end)
					lcd_alternation <= ~lcd_alternation;
			end else if (line_end) begin
				if (alt_cnt >= alternation_period - 8'h01) begin
					alt_cnt <= 8'h00;
					lcd_alternation <= ~lcd_alternation;
				end else begin
					alt_cnt <= alt_cnt + 8'h01;
				end
			end
		end
	end

endmodule // lcp_regs

// [lcp_regs_chk.sv]
module lcp_regs_chk (
	input wire clk,
	input wire rst,
	input wire [7:0] data_out,
	input wire data_oe,
	input wire register_select_n,
	input wire vram_select_n,
	input wire read_n,
	input wire wait_n,
	input wire steal_mode,
	input wire line_pulse,
	input wire frame_mark,
	input wire lcd_alternation,
	input wire [13:0] display_start
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	steal_only_a: assert property (
		$fell(wait_n) |-> steal_mode && !vram_select_n)
		else $error("wait without steal access");
	wait_bound_a: assert property ($fell(wait_n) |-> ##[1:60] wait_n)
		else $error("wait held too long");
	direct_nowait_a: assert property (!steal_mode |-> wait_n)
		else $error("wait outside steal");
	oe_read_a: assert property (data_oe |-> !$past(read_n, 2))
		else $error("data driven without read");
	pulse_one_a: assert property (line_pulse |=> !line_pulse)
		else $error("line pulse too long");
	alt_cause_a: assert property ($changed(lcd_alternation) |->
		line_pulse || frame_mark || $past(line_pulse) || $past(frame_mark))
		else $error("alternation toggled without line");
	start_write_a: assert property ($changed(display_start) |->
		!$past(register_select_n, 3) || !$past(register_select_n, 4))
		else $error("start address changed without write");
	read_first_a: assert property ($rose(wait_n) |-> $stable(data_out))
		else $error("read data late");
	wait_gap_a: assert property ($rose(wait_n) |-> wait_n [*3])
		else $error("wait again before strobes rose");
endmodule // lcp_regs_chk

bind lcp_regs lcp_regs_chk i_lcp_regs_chk (.clk(clk), .rst(rst),
	.data_out(data_out), .data_oe(data_oe),
	.register_select_n(register_select_n), .vram_select_n(vram_select_n),
	.read_n(read_n), .wait_n(wait_n), .steal_mode(steal_mode),
	.line_pulse(line_pulse), .frame_mark(frame_mark),
	.lcd_alternation(lcd_alternation), .display_start(display_start));

// [lcp_mpu.sv]
module lcp_mpu (
	input wire clk,
	input wire [7:0] data_out,
	input wire wait_n,
	output logic [13:0] addr = 14'h0000,
	output logic [7:0] data_in = 8'h00,
	output logic register_select_n = 1'b1,
	output logic vram_select_n = 1'b1,
	output logic low_byte_write_n = 1'b1,
	output logic high_byte_write_n = 1'b1,
	output logic read_n = 1'b1
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic access(input logic vram, input logic wr,
		input logic [13:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge clk);
		addr <= a;
		data_in <= d;
		register_select_n <= vram;
		vram_select_n <= !vram;
		low_byte_write_n <= !wr;
		read_n <= wr;
		repeat (4) @(posedge clk);
		n = 0;
		@(negedge clk);
		while (wait_n !== 1'b1 && n < 80) begin
			@(negedge clk);
			n++;
		end
		q = data_out;
		@(posedge clk);
		register_select_n <= 1'b1;
		vram_select_n <= 1'b1;
		low_byte_write_n <= 1'b1;
		read_n <= 1'b1;
		addr <= ~a;
		data_in <= ~d;
		repeat (3) @(posedge clk);
		#1;
	endtask
endmodule // lcp_mpu

// [lcp_regs_tb_top.sv]
`include "lcp_map.vh"
module lcp_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic steal_mode = 1'b0;
	logic [2:0] osc_div_sel = 3'h0;
	wire [13:0] addr, display_start;
	wire [7:0] data_in, data_out;
	wire data_oe, register_select_n, vram_select_n, low_byte_write_n;
	wire high_byte_write_n, read_n, wait_n, line_pulse, frame_mark;
	wire lcd_alternation;
	int error_cnt = 0;
	int checks_done = 0;
	logic [7:0] q, b;
	logic [13:0] a;
	int n;
	logic [4:0] ofs [8] = '{`LCP_OFS_VLINES, `LCP_OFS_START_LOW,
		`LCP_OFS_START_HIGH, `LCP_OFS_ALT_PERIOD, `LCP_OFS_INDEX_LOW,
		`LCP_OFS_INDEX_HIGH, 5'h02, 5'h16};
	logic [7:0] per [4] = '{8'h00, 8'h01, 8'h03, 8'hff};
	always #12.5 clk = ~clk;
	lcp_mpu i_lcp_mpu (.clk(clk), .data_out(data_out), .wait_n(wait_n),
		.addr(addr), .data_in(data_in), .register_select_n(register_select_n),
		.vram_select_n(vram_select_n), .low_byte_write_n(low_byte_write_n),
		.high_byte_write_n(high_byte_write_n), .read_n(read_n));
	lcp_regs #(.LINE_TICKS(16'h0004)) i_lcp_regs (.clk(clk), .rst(rst),
		.addr(addr), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .register_select_n(register_select_n),
		.vram_select_n(vram_select_n), .low_byte_write_n(low_byte_write_n),
		.high_byte_write_n(high_byte_write_n), .read_n(read_n),
		.wait_n(wait_n), .steal_mode(steal_mode), .osc_div_sel(osc_div_sel),
		.line_pulse(line_pulse), .frame_mark(frame_mark),
		.lcd_alternation(lcd_alternation), .display_start(display_start));
	task automatic check(input string what, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] o, input logic [7:0] d);
		logic [7:0] x;
		i_lcp_mpu.access(1'b0, 1'b1, {9'h000, o}, d, x);
	endtask
	task automatic rd(input logic [4:0] o, output logic [7:0] d);
		i_lcp_mpu.access(1'b0, 1'b0, {9'h000, o}, 8'h00, d);
	endtask
	task automatic set_index(input logic [13:0] i);
		wr(`LCP_OFS_INDEX_LOW, i[7:0]);
		wr(`LCP_OFS_INDEX_HIGH, {2'b00, i[13:8]});
	endtask
	// index after k data port accesses, wrapping at the end of vram
	function automatic logic [13:0] nidx(input logic [13:0] i, input int k);
		int s;
		s = (int'(i) + k) % `LCP_VRAM_BYTES;
		return 14'(s);
	endfunction
	// toggles are counted in line pulses; the first interval only syncs
	task automatic meas(output int cnt);
		logic s;
		for (int k = 0; k < 2; k++) begin
			s = lcd_alternation;
			cnt = 0;
			for (int t = 0; t < 3000 && lcd_alternation === s; t++) begin
				@(negedge clk);
				if (line_pulse === 1'b1)
					cnt++;
			end
		end
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#500us;
		error_cnt++;
		finish_test();
	end
	initial begin
		void'($urandom(32'h7f82));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		foreach (ofs[i]) begin
			rd(ofs[i], q);
			check("reset read", q, 8'h00);
		end
		$display("test reset values done");
		repeat (4) begin
			a = 14'($urandom_range(0, 14'h257f));
			wr(`LCP_OFS_START_LOW, a[7:0]);
			wr(`LCP_OFS_START_HIGH, {2'b11, a[13:8]});
			check("start pins", display_start, a);
			rd(`LCP_OFS_START_HIGH, q);
			check("start high", q, {2'b00, a[13:8]});
		end
		$display("test start address done");
		a = 14'($urandom_range(0, 14'h2500));
		set_index(a);
		for (n = 0; n < 3; n++)
			wr(`LCP_OFS_DATA_PORT, 8'(a + 14'(n)));
		rd(`LCP_OFS_INDEX_LOW, b);
		rd(`LCP_OFS_INDEX_HIGH, q);
		check("index", {q, b}, {2'b00, nidx(a, 3)});
		set_index(a);
		for (n = 0; n < 3; n++) begin
			rd(`LCP_OFS_DATA_PORT, q);
			check("port read", q, 8'(a + 14'(n)));
		end
		i_lcp_mpu.access(1'b1, 1'b0, a + 14'h1, 8'h00, q);
		check("direct read", q, 8'(a + 14'h1));
		set_index(`LCP_VRAM_LAST);
		wr(`LCP_OFS_DATA_PORT, 8'h5a);
		rd(`LCP_OFS_INDEX_LOW, b);
		rd(`LCP_OFS_INDEX_HIGH, q);
		check("index wrap", {q, b}, {2'b00, nidx(`LCP_VRAM_LAST, 1)});
		i_lcp_mpu.access(1'b1, 1'b0, `LCP_VRAM_LAST, 8'h00, q);
		check("last byte", q, 8'h5a);
		$display("test data port done");
		@(posedge clk);
		steal_mode <= 1'b1;
		for (n = 0; n < 5; n++) begin
			@(posedge clk);
			osc_div_sel <= 3'(n);
			b = 8'($urandom);
			i_lcp_mpu.access(1'b1, 1'b1, a + 14'(n), b, q);
			i_lcp_mpu.access(1'b1, 1'b0, a + 14'(n), 8'h00, q);
			check("steal read", q, b);
		end
		@(posedge clk);
		steal_mode <= 1'b0;
		osc_div_sel <= `LCP_DIV_NONE;
		$display("test cycle steal done");
		wr(`LCP_OFS_VLINES, 8'h05);
		foreach (per[i]) begin
			wr(`LCP_OFS_ALT_PERIOD, per[i]);
			meas(n);
			check("alt lines", 16'(n), (per[i] == 0) ? 16'h5 : 16'(per[i]));
		end
		$display("test alternation done");
		finish_test();
	end
endmodule // lcp_regs_tb_top
